// ===== core/tdm_switch_stream_config.sv
// Stream configuration of a TDM time-slot switch: rates, stream sets, delay type, offset.
// Assumes a host on the plain register port and pins synchronised here before use.
`timescale 1ns/1ps
`include "tdm_switch_consts.svh"

// How it works
// - At 2 Mb/s identical rate, select field picks wide, double, pairs or nibble.
// - Wide: eight by eight streams, 32 channels, 4 MHz clock, delay choice.
// - Double: inputs 0-15, outputs 0-7, variable delay, only in multiplexed bus mode.
// - Pairs: streams 0,1 fixed plus host pairs A and B from 2 to 9.
// - Nibble: 64 nibbles per stream, eight inputs, four outputs, blocking.
// - 4 Mb/s eight by four: 64 channels, 4 MHz clock, variable delay only.
// - 4 Mb/s four by four: 64 channels, 4 MHz clock, delay choice.
// - 8 Mb/s: two by two, 128 slots, 8 MHz clock, select field ignored.
// - Different rates: rates from both fields, select ignored, delay choice.
// - Conversion sets streams: 8x4, 8x2, 4x8 or 2x8 by rate pair.
// - Input offset works only when input rate is 4 or 8 Mb/s.
// - Offset delays input sampling and input frame by up to four cycles.
// - Output frame stays on the frame pulse whatever the offset.
// - Where a delay choice exists, each output channel takes variable or constant delay from its type bit.
// - Variable reads the current bank; constant keeps frame order by bank rotation.
// - Mode bit low means identical rates, high means different rates.
// - Identical rates take the input rate field and ignore the output field.
// - Constant delay reads out in frame N+2 what frame N wrote.
module tdm_switch_stream_config
  import tdm_switch_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Register port
  input  wire logic [2:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata_r,
  // Pins
  input  wire logic        frame_pulse_in,
  input  wire logic [15:0] serial_in_stream,
  input  wire logic        mux_bus_mode,
  // Upper connect memory delay type bit of the channel now being read
  input  wire logic        delay_type_bit,
  // Configuration results
  output logic      [15:0] in_en_r,
  output logic      [9:0]  out_en_r,
  output logic      [7:0]  chans_in_r,
  output logic      [7:0]  chans_out_r,
  output logic             clk_8m_r,
  output logic             delay_choice_r,
  output logic             blocking_r,
  output logic             nibble_r,
  output logic             cfg_bad_r,
  // Frame timing and data paths
  output logic      [15:0] sampled_in_r,
  output logic             in_frame_r,
  output logic             out_frame_r,
  output logic             var_delay_r,
  output logic      [1:0]  wr_bank_r,
  output logic      [1:0]  rd_bank_r
);

  cfg_state_type s_r;
  cfg_state_type s_nxt;

  rate_type    in_rate;
  rate_type    out_rate;
  cfg_type     cfg_sel;
  logic        diff_mode;
  logic        fp_rise;
  logic [3:0]  pair_a;
  logic [3:0]  pair_b;
  logic [2:0]  ofs_amt;
  logic [16:0] delayed;

  always_comb
  begin
    s_nxt     = s_r;
    fp_rise   = s_r.fp_s2 & ~s_r.fp_d;
    diff_mode = s_r.interface_mode_register[`MODE_DIFF_BIT];
    in_rate   = rate_type'(s_r.interface_mode_register[`MODE_IN_LSB +: 2]);
    out_rate  = rate_type'(s_r.interface_mode_register[`MODE_OUT_LSB +: 2]);
    cfg_sel   = cfg_type'(s_r.interface_mode_register[`MODE_CFG_LSB +: 2]);
    pair_a    = s_r.pair_select_register[`PAIR_A_LSB +: 4];
    pair_b    = s_r.pair_select_register[`PAIR_B_LSB +: 4];
    if (in_rate == RATE_RSV)
    begin
      in_rate = RATE_2M;
    end
    if (out_rate == RATE_RSV)
    begin
      out_rate = RATE_2M;
    end
    if (!diff_mode)
    begin
      out_rate = in_rate;
    end
    // Pin synchronisers
    s_nxt.fp_s1  = frame_pulse_in;
    s_nxt.fp_s2  = s_r.fp_s1;
    s_nxt.fp_d   = s_r.fp_s2;
    s_nxt.si_s1  = serial_in_stream;
    s_nxt.si_s2  = s_r.si_s1;
    s_nxt.mux_s1 = mux_bus_mode;
    s_nxt.mux_s2 = s_r.mux_s1;
    // Register writes
    if (wr)
    begin
      case (addr)
        `ADR_MODE:   s_nxt.interface_mode_register = wdata;
        `ADR_PAIR:   s_nxt.pair_select_register    = wdata;
        `ADR_OFFSET: s_nxt.input_offset_register   = wdata;
        default:     s_nxt.rdata = s_r.rdata;
      endcase
    end
    // Register reads, data valid only in the following cycle
    s_nxt.rdata = 8'h00;
    if (rd)
    begin
      case (addr)
        `ADR_MODE:   s_nxt.rdata = s_r.interface_mode_register;
        `ADR_PAIR:   s_nxt.rdata = s_r.pair_select_register;
        `ADR_OFFSET: s_nxt.rdata = s_r.input_offset_register;
        `ADR_STATUS:
        begin
          s_nxt.rdata[`ST_BLOCK_BIT]  = s_r.blocking;
          s_nxt.rdata[`ST_CHOICE_BIT] = s_r.delay_choice;
          s_nxt.rdata[`ST_CLK8_BIT]   = s_r.clk_8m;
          s_nxt.rdata[`ST_NIB_BIT]    = s_r.nibble;
          s_nxt.rdata[`ST_BAD_BIT]    = s_r.cfg_bad;
          s_nxt.rdata[`ST_OFS_BIT]    = s_r.ofs_active;
        end
        `ADR_IN_LO:  s_nxt.rdata = s_r.in_en[7:0];
        `ADR_IN_HI:  s_nxt.rdata = s_r.in_en[15:8];
        `ADR_OUT_LO: s_nxt.rdata = s_r.out_en[7:0];
        default:     s_nxt.rdata = {6'h00, s_r.out_en[9:8]};
      endcase
    end
    // Stream configuration decode
    s_nxt.nibble       = 1'b0;
    s_nxt.cfg_bad      = 1'b0;
    s_nxt.blocking     = 1'b0;
    s_nxt.delay_choice = 1'b1;
    s_nxt.clk_8m       = (in_rate == RATE_8M) || (out_rate == RATE_8M);
    s_nxt.in_en        = `IN_8;
    s_nxt.out_en       = `OUT_8;
    if (diff_mode)
    begin
      // Rate conversion sets its own streams; the select field is not looked at
      s_nxt.delay_choice = 1'b1;
      case ({in_rate, out_rate})
        {RATE_2M, RATE_4M}: s_nxt.out_en = `OUT_4;
        {RATE_2M, RATE_8M}: s_nxt.out_en = `OUT_2;
        {RATE_4M, RATE_2M}: s_nxt.in_en  = `IN_4;
        {RATE_8M, RATE_2M}: s_nxt.in_en  = `IN_2;
        default:            s_nxt.cfg_bad = 1'b1;
      endcase
    end
    else if (in_rate == RATE_8M)
    begin
      s_nxt.in_en  = `IN_2;
      s_nxt.out_en = `OUT_2;
    end
    else if (in_rate == RATE_4M)
    begin
      s_nxt.in_en  = `IN_4;
      s_nxt.out_en = `OUT_4;
      if (cfg_sel == CFG_WIDE)
      begin
        s_nxt.in_en        = `IN_8;
        s_nxt.blocking     = 1'b1;
        s_nxt.delay_choice = 1'b0;
      end
    end
    else
    begin
      case (cfg_sel)
        CFG_WIDE:
        begin
          s_nxt.in_en  = `IN_8;
          s_nxt.out_en = `OUT_8;
        end
        CFG_DOUBLE:
        begin
          if (s_r.mux_s2)
          begin
            s_nxt.in_en        = `IN_16;
            s_nxt.blocking     = 1'b1;
            s_nxt.delay_choice = 1'b0;
          end
          else
          begin
            s_nxt.cfg_bad = 1'b1;
          end
        end
        CFG_PAIRS:
        begin
          s_nxt.out_en = `PAIR_FIXED;
          for (int i = 2; i < 10; i++)
          begin
            if (pair_a == 4'(i) || pair_b == 4'(i))
            begin
              s_nxt.out_en[i] = 1'b1;
            end
          end
          if (pair_a < `PAIR_MIN || pair_a > `PAIR_MAX || pair_a == pair_b ||
              pair_b < `PAIR_MIN || pair_b > `PAIR_MAX)
          begin
            s_nxt.cfg_bad = 1'b1;
          end
          s_nxt.in_en = {6'h00, s_nxt.out_en};
        end
        CFG_NIBBLE:
        begin
          s_nxt.nibble       = 1'b1;
          s_nxt.out_en       = `OUT_4;
          s_nxt.blocking     = 1'b1;
          s_nxt.delay_choice = 1'b0;
        end
        default:
        begin
          s_nxt.cfg_bad = 1'b1;
        end
      endcase
    end
    // Channels per frame for each direction
    case (in_rate)
      RATE_8M: s_nxt.chans_in = `CH_128;
      RATE_4M: s_nxt.chans_in = `CH_64;
      default: s_nxt.chans_in = s_nxt.nibble ? `CH_64 : `CH_32;
    endcase
    case (out_rate)
      RATE_8M: s_nxt.chans_out = `CH_128;
      RATE_4M: s_nxt.chans_out = `CH_64;
      default: s_nxt.chans_out = s_nxt.nibble ? `CH_64 : `CH_32;
    endcase
    // Input offset, limited to four cycles and to fast inputs
    s_nxt.ofs_active = s_r.input_offset_register[`OFS_EN_BIT] &&
                       (in_rate != RATE_2M);
    ofs_amt = 3'h0;
    if (s_r.ofs_active)
    begin
      ofs_amt = s_r.input_offset_register[`OFS_AMT_LSB +: 3];
      if (ofs_amt > `OFS_MAX)
      begin
        ofs_amt = `OFS_MAX;
      end
    end
    // Output frame follows the frame pulse directly
    s_nxt.out_frame = fp_rise;
    // Data memory banks rotate once per frame
    if (fp_rise)
    begin
      s_nxt.wr_bank = (s_r.wr_bank == `BANK_LAST) ? 2'h0 : s_r.wr_bank + 2'h1;
    end
    s_nxt.var_delay = !(s_nxt.delay_choice && delay_type_bit);
    if (s_nxt.var_delay)
    begin
      s_nxt.rd_bank = s_nxt.wr_bank;
    end
    else
    begin
      s_nxt.rd_bank = (s_nxt.wr_bank == `BANK_LAST) ? 2'h0 : s_nxt.wr_bank + 2'h1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s_r <= '0;
      s_r.interface_mode_register <= `MODE_RST;
      s_r.pair_select_register    <= `PAIR_RST;
      s_r.input_offset_register   <= `OFFSET_RST;
      s_r.in_en                   <= `IN_8;
      s_r.out_en                  <= `OUT_8;
      s_r.chans_in                <= `CH_32;
      s_r.chans_out               <= `CH_32;
      s_r.delay_choice            <= 1'b1;
      s_r.var_delay               <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // Offset delay on input samples and the input frame mark
  offset_delay_line u_delay (
    .clk_sys (clk_sys),
    .rst     (rst),
    .din     ({fp_rise, s_r.si_s2}),
    .amt     (ofs_amt),
    .dout_r  (delayed)
  );

  assign rdata_r        = s_r.rdata;
  assign in_en_r        = s_r.in_en;
  assign out_en_r       = s_r.out_en;
  assign chans_in_r     = s_r.chans_in;
  assign chans_out_r    = s_r.chans_out;
  assign clk_8m_r       = s_r.clk_8m;
  assign delay_choice_r = s_r.delay_choice;
  assign blocking_r     = s_r.blocking;
  assign nibble_r       = s_r.nibble;
  assign cfg_bad_r      = s_r.cfg_bad;
  assign sampled_in_r   = delayed[15:0];
  assign in_frame_r     = delayed[16];
  assign out_frame_r    = s_r.out_frame;
  assign var_delay_r    = s_r.var_delay;
  assign wr_bank_r      = s_r.wr_bank;
  assign rd_bank_r      = s_r.rd_bank;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_frame_out_align: assert property (fp_rise |=> out_frame_r)
    else $error("output frame not on frame pulse");
  chk_offset_off_align: assert property (
    out_frame_r && !s_r.ofs_active ##0 $stable(s_r.ofs_active) |-> in_frame_r)
    else $error("input frame moved without offset");
  chk_offset_four_late: assert property (
    fp_rise && ofs_amt == 3'h4 ##1 (ofs_amt == 3'h4)[*4] |=> in_frame_r)
    else $error("input frame not four cycles late");
  chk_fast_rate_pair: assert property (
    !diff_mode && in_rate == RATE_8M |=> in_en_r == `IN_2 && out_en_r == `OUT_2)
    else $error("fast rate streams wrong");
  chk_pairs_fixed: assert property (
    !diff_mode && in_rate == RATE_2M && cfg_sel == CFG_PAIRS |=> out_en_r[1:0] == 2'b11)
    else $error("fixed stream pairs missing");
  chk_nibble_set: assert property (
    !diff_mode && in_rate == RATE_2M && cfg_sel == CFG_NIBBLE
    |=> nibble_r && out_en_r == `OUT_4 && in_en_r == `IN_8 && chans_in_r == `CH_64)
    else $error("nibble arrangement wrong");
  chk_double_gate: assert property (
    !diff_mode && in_rate == RATE_2M && cfg_sel == CFG_DOUBLE && !s_r.mux_s2
    |=> in_en_r != `IN_16 && cfg_bad_r)
    else $error("double arrangement without multiplexed bus");
  chk_convert_streams: assert property (
    diff_mode && in_rate == RATE_2M && out_rate == RATE_8M
    |=> in_en_r == `IN_8 && out_en_r == `OUT_2 && clk_8m_r)
    else $error("conversion streams wrong");
  chk_var_forced: assert property (!delay_choice_r |-> var_delay_r)
    else $error("constant delay where no choice exists");
  chk_bank_advance: assert property (
    out_frame_r |-> wr_bank_r != $past(wr_bank_r) && wr_bank_r <= `BANK_LAST)
    else $error("bank did not rotate on frame");

  cov_offset_used: cover property (s_r.ofs_active && in_frame_r);
  cov_const_delay: cover property (!var_delay_r && out_frame_r);
  cov_pairs_mode:  cover property (cfg_sel == CFG_PAIRS ##1 !cfg_bad_r);
  cov_convert:     cover property (diff_mode ##1 !cfg_bad_r);

endmodule : tdm_switch_stream_config

// ===== core/tdm_switch_consts.svh
// Offsets, field positions, reset values and counts of the stream configuration block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef TDM_SWITCH_CONSTS_SVH
`define TDM_SWITCH_CONSTS_SVH

// Register indexes on the 3-bit register port
`define ADR_MODE      3'h0
`define ADR_PAIR      3'h1
`define ADR_OFFSET    3'h2
`define ADR_STATUS    3'h3
`define ADR_IN_LO     3'h4
`define ADR_IN_HI     3'h5
`define ADR_OUT_LO    3'h6
`define ADR_OUT_HI    3'h7

// Field positions
`define MODE_DIFF_BIT 0
`define MODE_IN_LSB   1
`define MODE_OUT_LSB  3
`define MODE_CFG_LSB  5
`define PAIR_A_LSB    0
`define PAIR_B_LSB    4
`define OFS_EN_BIT    0
`define OFS_AMT_LSB   1
`define ST_BLOCK_BIT  0
`define ST_CHOICE_BIT 1
`define ST_CLK8_BIT   2
`define ST_NIB_BIT    3
`define ST_BAD_BIT    4
`define ST_OFS_BIT    5

// Reset values
`define MODE_RST      8'h00
`define PAIR_RST      8'h32
`define OFFSET_RST    8'h00

// Counts and limits
`define OFS_MAX       3'h4
`define PAIR_MIN      4'h2
`define PAIR_MAX      4'h9
`define CH_32         8'h20
`define CH_64         8'h40
`define CH_128        8'h80
`define BANK_LAST     2'h2
`define TAPS          4

// Stream masks
`define IN_2          16'h0003
`define IN_4          16'h000F
`define IN_8          16'h00FF
`define IN_16         16'hFFFF
`define OUT_2         10'h003
`define OUT_4         10'h00F
`define OUT_8         10'h0FF
`define PAIR_FIXED    10'h003

`endif

// ===== core/tdm_switch_pkg.sv
// Types shared by the stream configuration block and its offset delay line.
// Assumes the constants header sits beside it.
`include "tdm_switch_consts.svh"

package tdm_switch_pkg;

  typedef enum logic [1:0] {
    RATE_2M  = 2'b00,
    RATE_4M  = 2'b01,
    RATE_8M  = 2'b10,
    RATE_RSV = 2'b11
  } rate_type;

  typedef enum logic [1:0] {
    CFG_WIDE   = 2'b00,
    CFG_DOUBLE = 2'b01,
    CFG_PAIRS  = 2'b10,
    CFG_NIBBLE = 2'b11
  } cfg_type;

  typedef struct packed {
    logic [`TAPS-1:0][16:0] taps;
    logic [16:0]            dout;
  } delay_state_type;

  typedef struct packed {
    logic        fp_s1;
    logic        fp_s2;
    logic        fp_d;
    logic [15:0] si_s1;
    logic [15:0] si_s2;
    logic        mux_s1;
    logic        mux_s2;
    logic [7:0]  interface_mode_register;
    logic [7:0]  pair_select_register;
    logic [7:0]  input_offset_register;
    logic [7:0]  rdata;
    logic [15:0] in_en;
    logic [9:0]  out_en;
    logic [7:0]  chans_in;
    logic [7:0]  chans_out;
    logic        clk_8m;
    logic        delay_choice;
    logic        blocking;
    logic        nibble;
    logic        cfg_bad;
    logic        ofs_active;
    logic        out_frame;
    logic        var_delay;
    logic [1:0]  wr_bank;
    logic [1:0]  rd_bank;
  } cfg_state_type;

endpackage : tdm_switch_pkg

// ===== core/offset_delay_line.sv
// Delay line that shifts sampled serial inputs and the frame mark by 0 to 4 cycles.
// Assumes inputs already synchronised to clk_sys and an amount no larger than four.
`timescale 1ns/1ps
`include "tdm_switch_consts.svh"

module offset_delay_line
  import tdm_switch_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Data in, amount, data out
  input  wire logic [16:0] din,
  input  wire logic [2:0]  amt,
  output logic      [16:0] dout_r
);

  delay_state_type s_r;
  delay_state_type s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.taps[0] = din;
    for (int i = 1; i < `TAPS; i++)
    begin
      s_nxt.taps[i] = s_r.taps[i-1];
    end
    if (amt == 3'h0)
    begin
      s_nxt.dout = din;
    end
    else
    begin
      s_nxt.dout = s_r.taps[amt[1:0] - 2'h1];
    end
    if (amt >= `OFS_MAX)
    begin
      s_nxt.dout = s_r.taps[`TAPS-1];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign dout_r = s_r.dout;

endmodule : offset_delay_line

// ===== test/tdm_backplane_model.sv
// Backplane side model: frame pulses, serial stream data and the connect memory type bit.
// Assumes the bench clock and reset; frames start once reset is released.
`timescale 1ns/1ps

module tdm_backplane_model #(
  parameter int FRAME_CYC = 40
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Bench control
  input  wire logic        const_sel,
  // Pins toward the switch
  output logic             frame_pulse_in,
  output logic      [15:0] serial_in_stream,
  output logic             delay_type_bit
);
  logic [7:0] cnt_r;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cnt_r            <= 8'h00;
      frame_pulse_in   <= 1'b0;
      serial_in_stream <= 16'h0000;
      delay_type_bit   <= 1'b0;
    end
    else
    begin
      cnt_r            <= (cnt_r == 8'(FRAME_CYC - 1)) ? 8'h00 : cnt_r + 8'h01;
      frame_pulse_in   <= (cnt_r == 8'(FRAME_CYC - 1));
      serial_in_stream <= {cnt_r, ~cnt_r};
      delay_type_bit   <= const_sel;
    end
  end
endmodule : tdm_backplane_model

// ===== test/test_tdm_switch_stream_config.sv
// Self-checking bench of the stream configuration block: table of modes, then hand tests.
// Assumes the backplane model on the pins and a host on the plain register port.
`timescale 1ns/1ps

module test_tdm_switch_stream_config;
  import tdm_switch_pkg::*;

  typedef struct packed {
    logic [7:0]  mode;
    logic        mux;
    logic [15:0] ine;
    logic [9:0]  oute;
    logic [7:0]  chi;
    logic [7:0]  cho;
    logic [5:0]  st;
  } row_type;

  localparam row_type ROWS [12] = '{
    '{8'h00, 1'b0, 16'h00FF, 10'h0FF, 8'h20, 8'h20, 6'h02},
    '{8'h18, 1'b0, 16'h00FF, 10'h0FF, 8'h20, 8'h20, 6'h02},
    '{8'h20, 1'b1, 16'hFFFF, 10'h0FF, 8'h20, 8'h20, 6'h01},
    '{8'h40, 1'b0, 16'h000F, 10'h00F, 8'h20, 8'h20, 6'h02},
    '{8'h60, 1'b0, 16'h00FF, 10'h00F, 8'h40, 8'h40, 6'h09},
    '{8'h02, 1'b0, 16'h00FF, 10'h00F, 8'h40, 8'h40, 6'h01},
    '{8'h22, 1'b0, 16'h000F, 10'h00F, 8'h40, 8'h40, 6'h02},
    '{8'h64, 1'b0, 16'h0003, 10'h003, 8'h80, 8'h80, 6'h06},
    '{8'h69, 1'b0, 16'h00FF, 10'h00F, 8'h20, 8'h40, 6'h02},
    '{8'h11, 1'b0, 16'h00FF, 10'h003, 8'h20, 8'h80, 6'h06},
    '{8'h03, 1'b0, 16'h000F, 10'h0FF, 8'h40, 8'h20, 6'h02},
    '{8'h05, 1'b0, 16'h0003, 10'h0FF, 8'h80, 8'h20, 6'h06}
  };

  // Clock, reset and host port
  logic        clk_sys;
  logic        rst;
  logic [2:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic        mux_bus_mode;
  logic        const_sel;
  // Pins and results
  logic        frame_pulse_in;
  logic [15:0] serial_in_stream;
  logic        delay_type_bit;
  logic [7:0]  rdata_r;
  logic [15:0] in_en_r;
  logic [9:0]  out_en_r;
  logic [7:0]  chans_in_r;
  logic [7:0]  chans_out_r;
  logic        clk_8m_r;
  logic        delay_choice_r;
  logic        blocking_r;
  logic        nibble_r;
  logic        cfg_bad_r;
  logic        in_frame_r;
  logic [15:0] sampled_in_r;
  logic        out_frame_r;
  logic        var_delay_r;
  logic [1:0]  wr_bank_r;
  logic [1:0]  rd_bank_r;
  int          err_count;
  int          comparisons;

  tdm_switch_stream_config uut (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata_r(rdata_r), .frame_pulse_in(frame_pulse_in),
    .serial_in_stream(serial_in_stream), .mux_bus_mode(mux_bus_mode),
    .delay_type_bit(delay_type_bit), .in_en_r(in_en_r), .out_en_r(out_en_r),
    .chans_in_r(chans_in_r), .chans_out_r(chans_out_r), .clk_8m_r(clk_8m_r),
    .delay_choice_r(delay_choice_r), .blocking_r(blocking_r), .nibble_r(nibble_r),
    .cfg_bad_r(cfg_bad_r), .sampled_in_r(sampled_in_r), .in_frame_r(in_frame_r),
    .out_frame_r(out_frame_r), .var_delay_r(var_delay_r), .wr_bank_r(wr_bank_r),
    .rd_bank_r(rd_bank_r));

  tdm_backplane_model far_side (.clk_sys(clk_sys), .rst(rst), .const_sel(const_sel),
    .frame_pulse_in(frame_pulse_in), .serial_in_stream(serial_in_stream),
    .delay_type_bit(delay_type_bit));

  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic results();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic check_cycles(input string name, input int exp, input int got);
    comparisons++;
    if (got != exp)
    begin
      err_count++;
      $display("unexpected %s expected %0d seen %0d", name, exp, got);
    end
  endtask : check_cycles

  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr    <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : reg_wr

  task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys);
    rd   <= 1'b0;
    #1;
    d = rdata_r;
  endtask : reg_rd

  task automatic wait_out(output int n);
    n = 0;
    while (out_frame_r !== 1'b1 && n < 100)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (out_frame_r !== 1'b1)
    begin
      err_count++;
      results();
    end
  endtask : wait_out

  logic [7:0]  d;
  logic [7:0]  pairs [3] = '{8'h94, 8'h22, 8'hA2};
  logic [7:0]  omode [3] = '{8'h00, 8'h22, 8'h04};
  logic [7:0]  oval  [3] = '{8'h07, 8'h05, 8'h0F};
  int          ogap  [3] = '{0, 2, 4};
  logic [1:0]  b;
  logic [1:0]  bn;
  logic [4:0]  flags;
  int          n;

  assign flags = {cfg_bad_r, nibble_r, clk_8m_r, delay_choice_r, blocking_r};
  int          gap;

  initial
  begin
    rst = 1'b1; addr = 3'h0; wdata = 8'h00; wr = 1'b0; rd = 1'b0;
    mux_bus_mode = 1'b0; const_sel = 1'b0; err_count = 0; comparisons = 0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    check("in_en", 16'h00FF, in_en_r);
    check("out_en", 16'h00FF, {6'h00, out_en_r});
    check("chans", 16'h2020, {chans_in_r, chans_out_r});
    check("choice", 16'h0001, {15'h0000, delay_choice_r});
    check("var", 16'h0001, {15'h0000, var_delay_r});
    check("rdata idle", 16'h0000, {8'h00, rdata_r});
    reg_rd(3'h0, d);
    check("mode rst", 16'h0000, {8'h00, d});
    reg_rd(3'h1, d);
    check("pair rst", 16'h0032, {8'h00, d});
    reg_wr(3'h2, 8'h00);
    // Table of arrangements
    foreach (ROWS[i])
    begin
      mux_bus_mode <= ROWS[i].mux;
      reg_wr(3'h0, ROWS[i].mode);
      check("in_en", ROWS[i].ine, in_en_r);
      check("out_en", {6'h00, ROWS[i].oute}, {6'h00, out_en_r});
      check("chans", {ROWS[i].chi, ROWS[i].cho}, {chans_in_r, chans_out_r});
      reg_rd(3'h3, d);
      check("status", {10'h000, ROWS[i].st}, {10'h000, d[5:0]});
      check("flags", {11'h000, ROWS[i].st[4:0]}, {11'h000, flags});
      reg_rd(3'h4, d);
      check("in_en lo", {8'h00, ROWS[i].ine[7:0]}, {8'h00, d});
    end
    // Sixteen by eight refused without the multiplexed bus
    mux_bus_mode <= 1'b0;
    reg_wr(3'h0, 8'h20);
    check("bad double", 16'h0001, {15'h0000, cfg_bad_r});
    check("in_en double", 16'h00FF, in_en_r);
    reg_wr(3'h0, 8'h01);
    check("bad equal", 16'h0001, {15'h0000, cfg_bad_r});
    // Pair selection: valid, duplicate, out of range
    reg_wr(3'h0, 8'h40);
    foreach (pairs[i])
    begin
      reg_wr(3'h1, pairs[i]);
      check("pair bad", {15'h0000, i != 0}, {15'h0000, cfg_bad_r});
    end
    reg_wr(3'h1, 8'h94);
    check("pair in", 16'h0213, in_en_r);
    check("pair out", 16'h0213, {6'h00, out_en_r});
    reg_rd(3'h5, d);
    check("in_en hi", 16'h0002, {8'h00, d});
    reg_rd(3'h6, d);
    check("out_en lo", 16'h0013, {8'h00, d});
    reg_rd(3'h7, d);
    check("out_en hi", 16'h0002, {8'h00, d});
    reg_wr(3'h3, 8'hFF);
    reg_rd(3'h3, d);
    check("status ro", 16'h0002, {10'h000, d[5:0]});
    // Input frame offset
    foreach (omode[i])
    begin
      reg_wr(3'h0, omode[i]);
      reg_wr(3'h2, oval[i]);
      reg_rd(3'h3, d);
      check("ofs active", {15'h0000, i != 0}, {15'h0000, d[5]});
      repeat (4) @(posedge clk_sys);
      #1;
      wait_out(n);
      gap = 0;
      while (in_frame_r !== 1'b1 && gap < 10)
      begin
        @(posedge clk_sys);
        #1;
        gap++;
      end
      check_cycles("in frame gap", ogap[i], gap);
      check("in data", 16'h27D8, sampled_in_r);
      if (gap == 10)
      begin
        results();
      end
    end
    n = 0;
    while (frame_pulse_in !== 1'b1 && n < 100)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (frame_pulse_in !== 1'b1)
    begin
      err_count++;
      results();
    end
    gap = 0;
    while (out_frame_r !== 1'b1 && gap < 10)
    begin
      @(posedge clk_sys);
      #1;
      gap++;
    end
    check_cycles("out frame lat", 3, gap);
    if (gap == 10)
    begin
      results();
    end
    // Delay type and bank rotation
    reg_wr(3'h2, 8'h00);
    reg_wr(3'h0, 8'h00);
    for (int k = 0; k < 3; k++)
    begin
      wait_out(n);
      b = wr_bank_r;
      bn = (b == 2'h2) ? 2'h0 : b + 2'h1;
      const_sel <= 1'b1;
      repeat (3) @(posedge clk_sys);
      #1;
      check("var const", 16'h0000, {15'h0000, var_delay_r});
      check("rd bank const", {14'h0000, bn}, {14'h0000, rd_bank_r});
      const_sel <= 1'b0;
      repeat (3) @(posedge clk_sys);
      #1;
      check("rd bank var", {14'h0000, b}, {14'h0000, rd_bank_r});
      @(posedge clk_sys);
      #1;
      wait_out(n);
      check("wr bank", {14'h0000, bn}, {14'h0000, wr_bank_r});
    end
    reg_wr(3'h0, 8'h02);
    const_sel <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    check("var forced", 16'h0001, {15'h0000, var_delay_r});
    check("rd bank forced", {14'h0000, wr_bank_r}, {14'h0000, rd_bank_r});
    results();
  end
endmodule : test_tdm_switch_stream_config
